// ### common/reset_seq_pkg.sv
// reset sequencer package: register map, field positions, reset values and timing
package reset_seq_pkg;
   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned POR_EXT_NS = 30000;
   localparam int unsigned BOR_EXT_NS = 100000;
   localparam int unsigned PLL_LOCK_NS = 1500000;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned PIN_FILTER_NS = 200;
   // longest times round down
   localparam int unsigned POR_EXT_CYCLES = POR_EXT_NS / CLK_PERIOD_NS;
   localparam int unsigned BOR_EXT_CYCLES_DEF = BOR_EXT_NS / CLK_PERIOD_NS;
   localparam int unsigned PLL_LOCK_CYCLES_DEF = PLL_LOCK_NS / CLK_PERIOD_NS;
   localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
   localparam logic [3:0] PIN_FILTER_CYCLES = 4'(PIN_FILTER_NS / CLK_PERIOD_NS);
   localparam logic [31:0] OST_PERIODS = 32'h0000_0400;
   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [3:0] OFS_CAUSE = 4'h0;
   localparam logic [3:0] OFS_CONFIG = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   // reset-cause register bits
   localparam int unsigned BIT_POWER_ON = 0;
   localparam int unsigned BIT_BROWNOUT = 1;
   localparam int unsigned BIT_IDLE = 2;
   localparam int unsigned BIT_SLEEP = 3;
   localparam int unsigned BIT_WDT_TIMEOUT = 4;
   localparam int unsigned BIT_SOFT_RESET = 6;
   localparam int unsigned BIT_PIN_RESET = 7;
   localparam int unsigned BIT_CFG_MISMATCH = 9;
   localparam int unsigned BIT_ILLEGAL = 14;
   localparam int unsigned BIT_TRAP_CONFLICT = 15;
   localparam logic [15:0] CAUSE_WR_MASK = 16'hC2DF;
   localparam logic [15:0] CAUSE_RESET = 16'h0003;
   // flags wiped by any cold reset, and the pin flag by power-on only
   localparam logic [15:0] COLD_CLEAR_MASK = 16'hC25C;
   localparam logic [15:0] POR_CLEAR_MASK = 16'h0080;
   // config register fields
   localparam int unsigned CFG_POWERUP_DELAY_TIMER_LSB = 0;
   localparam int unsigned CFG_CLK_LSB = 4;
   localparam int unsigned CFG_XTAL_BIT = 8;
   localparam logic [2:0] POWERUP_DELAY_TIMER_SEL_RESET = 3'h7;
   localparam logic [2:0] COLD_CLK_RESET = 3'h0;
   localparam logic XTAL_RESET = 1'b1;
   // status register fields
   localparam int unsigned STS_STATE_LSB = 0;
   localparam int unsigned STS_CLK_LSB = 4;
   localparam int unsigned STS_CORE_RST_BIT = 8;
   localparam int unsigned STS_CLK_READY_BIT = 9;
   // ************************************************************
   // clock sources, opcodes, vectors, traps
   // ************************************************************
   localparam logic [2:0] CLK_FRC = 3'h0;
   localparam logic [2:0] CLK_FRCPLL = 3'h1;
   localparam logic [2:0] CLK_PRI = 3'h2;
   localparam logic [2:0] CLK_PRIPLL = 3'h3;
   localparam logic [2:0] CLK_SOSC = 3'h4;
   localparam logic [2:0] CLK_LPRC = 3'h5;
   localparam logic [7:0] ILLEGAL_OPCODE_HI = 8'h3F;
   localparam logic [23:0] RESET_VECTOR = 24'h00_0000;
   localparam logic [3:0] HARD_TRAP_MIN = 4'hD;
   localparam logic [3:0] HARD_TRAP_MAX = 4'hF;
   localparam logic [31:0] PPS_RESET = 32'h0000_0000;
   // ************************************************************
   // sequencer states, Gray along the power-on path
   // ************************************************************
   typedef enum logic [2:0] {
      ST_HOLD = 3'b000,
      ST_PEXT = 3'b001,
      ST_BEXT = 3'b011,
      ST_POWERUP_DELAY_TIMER = 3'b010,
      ST_OST = 3'b110,
      ST_LOCK = 3'b111,
      ST_RUN = 3'b101,
      ST_WARM = 3'b100
   } seq_state_t;
endpackage

// ### design/reset_source_sequencer.sv
// reset sequencer and reset-cause recorder with an Avalon-MM register slave
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module reset_source_sequencer
   import reset_seq_pkg::*;
#(
   parameter int unsigned BOR_EXT_CYCLES = BOR_EXT_CYCLES_DEF,
   parameter int unsigned PLL_LOCK_CYCLES = PLL_LOCK_CYCLES_DEF,
   parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // avalon-mm slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // supply monitors
   input wire logic por_supply_ok,
   input wire logic bor_supply_ok,
   // oscillator
   input wire logic osc_tick,
   output logic [2:0] current_clock_select,
   output logic osc_enable,
   // external reset pin
   input wire logic ext_reset_pin_n,
   // watchdog and power save
   input wire logic watchdog_timeout,
   input wire logic power_saving,
   input wire logic power_save_op,
   input wire logic power_save_sleep,
   input wire logic watchdog_clear_op,
   output logic wake,
   // core events
   input wire logic soft_reset_exec,
   input wire logic trap_active,
   input wire logic [3:0] trap_active_prio,
   input wire logic trap_new,
   input wire logic [3:0] trap_new_prio,
   input wire logic opcode_valid,
   input wire logic [23:0] opcode,
   input wire logic w_write_en,
   input wire logic [3:0] w_write_idx,
   input wire logic w_ptr_use,
   input wire logic [3:0] w_ptr_idx,
   input wire logic branch_flow_change,
   input wire logic vector_flow_change,
   input wire logic [23:0] flow_target,
   input wire logic protect_enable,
   input wire logic [23:0] protect_base,
   input wire logic [23:0] protect_limit,
   // pin-select configuration
   input wire logic pps_write,
   input wire logic [31:0] pps_write_data,
   input wire logic [31:0] pps_live,
   // core side
   output logic core_reset,
   output logic fetch_start,
   output logic [23:0] reset_vector
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      seq_state_t state;
      logic [31:0] cnt;
      logic cold_por;
      logic [15:0] cause;
      logic [2:0] powerup_delay_timer_sel;
      logic [2:0] cold_sel;
      logic xtal;
      logic [2:0] cur_clk;
      logic pin_s1;
      logic pin_s2;
      logic [3:0] pin_cnt;
      logic pin_low;
      logic [31:0] shadow;
      logic [14:0] w_init;
      logic rd_ack;
      logic [31:0] rdata;
      logic fetch_start;
      logic wake;
   } regs_t;

   regs_t s_r;
   regs_t s_nxt;

   logic running;
   logic wdt_rst;
   logic trap_conflict;
   logic cfg_mismatch;
   logic bad_opcode;
   logic uninit_ptr;
   logic sec_violation;
   logic illegal_any;
   logic warm_evt;
   logic need_ost;
   logic need_pll;
   logic [31:0] powerup_delay_timer_target;
   logic [31:0] cnt_inc;
   logic [15:0] cause_wr;
   logic [31:0] rd_mux;

   assign running = (s_r.state == ST_RUN);
   assign wdt_rst = watchdog_timeout & ~power_saving;
   assign trap_conflict = running & trap_active & trap_new &
      (trap_new_prio >= HARD_TRAP_MIN) & (trap_new_prio <= HARD_TRAP_MAX) &
      (trap_new_prio < trap_active_prio);
   // a legitimate write this cycle refreshes the shadow, so it is not a mismatch
   assign cfg_mismatch = running & ~pps_write & (pps_live != s_r.shadow);
   assign bad_opcode = running & opcode_valid & (opcode[23:16] == ILLEGAL_OPCODE_HI);
   // W15 is the stack pointer and never counts as uninitialised
   assign uninit_ptr = running & w_ptr_use & (w_ptr_idx != 4'hF) &
      ~s_r.w_init[w_ptr_idx];
   assign sec_violation = running & protect_enable &
      (branch_flow_change | vector_flow_change) &
      (flow_target >= protect_base) & (flow_target <= protect_limit);
   assign illegal_any = bad_opcode | uninit_ptr | sec_violation;
   assign warm_evt = soft_reset_exec | wdt_rst | trap_conflict | cfg_mismatch |
      illegal_any | s_r.pin_low;
   assign need_ost = (s_r.xtal & ((s_r.cur_clk == CLK_PRI) | (s_r.cur_clk == CLK_PRIPLL))) |
      (s_r.cur_clk == CLK_SOSC);
   assign need_pll = (s_r.cur_clk == CLK_FRCPLL) | (s_r.cur_clk == CLK_PRIPLL);
   assign powerup_delay_timer_target = (s_r.powerup_delay_timer_sel == 3'h0) ? 32'h0000_0000 :
      (32'(MS_CYCLES) << s_r.powerup_delay_timer_sel);
   assign cnt_inc = s_r.cnt + 32'h0000_0001;

   // ************************************************************
   // bus read mux
   // ************************************************************
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (address)
         OFS_CAUSE: rd_mux = {16'h0000, s_r.cause};
         OFS_CONFIG: begin
            rd_mux[CFG_POWERUP_DELAY_TIMER_LSB +: 3] = s_r.powerup_delay_timer_sel;
            rd_mux[CFG_CLK_LSB +: 3] = s_r.cold_sel;
            rd_mux[CFG_XTAL_BIT] = s_r.xtal;
         end
         OFS_STATUS: begin
            rd_mux[STS_STATE_LSB +: 3] = s_r.state;
            rd_mux[STS_CLK_LSB +: 3] = s_r.cur_clk;
            rd_mux[STS_CORE_RST_BIT] = core_reset;
            rd_mux[STS_CLK_READY_BIT] = running;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      s_nxt = s_r;
      s_nxt.fetch_start = 1'b0;
      s_nxt.wake = watchdog_timeout & power_saving;
      // bus: reads take one wait cycle, writes land at once
      s_nxt.rd_ack = read & ~s_r.rd_ack;
      if (read & ~s_r.rd_ack) begin
         s_nxt.rdata = rd_mux;
      end
      cause_wr = s_r.cause;
      if (write & (address == OFS_CAUSE)) begin
         if (byteenable[0]) begin
            cause_wr[7:0] = writedata[7:0];
         end
         if (byteenable[1]) begin
            cause_wr[15:8] = writedata[15:8];
         end
      end
      s_nxt.cause = cause_wr & CAUSE_WR_MASK;
      if (write & (address == OFS_CONFIG)) begin
         if (byteenable[0]) begin
            s_nxt.powerup_delay_timer_sel = writedata[CFG_POWERUP_DELAY_TIMER_LSB +: 3];
            s_nxt.cold_sel = writedata[CFG_CLK_LSB +: 3];
         end
         if (byteenable[1]) begin
            s_nxt.xtal = writedata[CFG_XTAL_BIT];
         end
      end
      // operation clears first, so a timeout in the same cycle still sets
      if (power_save_op | watchdog_clear_op) begin
         s_nxt.cause[BIT_WDT_TIMEOUT] = 1'b0;
      end
      if (power_save_op) begin
         s_nxt.cause[BIT_SLEEP] = s_nxt.cause[BIT_SLEEP] | power_save_sleep;
         s_nxt.cause[BIT_IDLE] = s_nxt.cause[BIT_IDLE] | ~power_save_sleep;
      end
      // every cause of this cycle is flagged together
      if (wdt_rst) begin
         s_nxt.cause[BIT_WDT_TIMEOUT] = 1'b1;
      end
      if (trap_conflict) begin
         s_nxt.cause[BIT_TRAP_CONFLICT] = 1'b1;
      end
      if (cfg_mismatch) begin
         s_nxt.cause[BIT_CFG_MISMATCH] = 1'b1;
      end
      if (illegal_any) begin
         s_nxt.cause[BIT_ILLEGAL] = 1'b1;
      end
      if (running & soft_reset_exec) begin
         s_nxt.cause[BIT_SOFT_RESET] = 1'b1;
      end
      if (s_r.pin_low) begin
         s_nxt.cause[BIT_PIN_RESET] = 1'b1;
      end
      // pin filter on the second synchroniser stage only
      s_nxt.pin_s1 = ext_reset_pin_n;
      s_nxt.pin_s2 = s_r.pin_s1;
      if (s_r.pin_s2) begin
         s_nxt.pin_cnt = 4'h0;
      end else if (s_r.pin_cnt != PIN_FILTER_CYCLES) begin
         s_nxt.pin_cnt = s_r.pin_cnt + 4'h1;
      end
      s_nxt.pin_low = ~s_r.pin_s2 & (s_nxt.pin_cnt == PIN_FILTER_CYCLES);
      if (pps_write) begin
         s_nxt.shadow = pps_write_data;
      end
      if (running & w_write_en & (w_write_idx != 4'hF)) begin
         s_nxt.w_init[w_write_idx[3:0]] = 1'b1;
      end
      // sequencer
      unique case (s_r.state)
         ST_HOLD: begin
            s_nxt.cnt = 32'h0000_0000;
            s_nxt.state = s_r.cold_por ? ST_PEXT : ST_BEXT;
         end
         ST_PEXT: begin
            s_nxt.cnt = cnt_inc;
            if (cnt_inc >= 32'(POR_EXT_CYCLES)) begin
               s_nxt.cnt = 32'h0000_0000;
               s_nxt.state = ST_BEXT;
            end
         end
         ST_BEXT: begin
            s_nxt.cnt = cnt_inc;
            if (cnt_inc >= 32'(BOR_EXT_CYCLES)) begin
               s_nxt.cnt = 32'h0000_0000;
               s_nxt.cold_por = 1'b0;
               s_nxt.cur_clk = s_r.cold_sel;
               s_nxt.state = ST_POWERUP_DELAY_TIMER;
            end
         end
         ST_POWERUP_DELAY_TIMER: begin
            s_nxt.cnt = cnt_inc;
            if (cnt_inc >= powerup_delay_timer_target) begin
               s_nxt.cnt = 32'h0000_0000;
               s_nxt.state = ST_OST;
            end
         end
         ST_OST: begin
            if (!need_ost) begin
               s_nxt.state = ST_LOCK;
            end else if (osc_tick) begin
               s_nxt.cnt = cnt_inc;
               if (cnt_inc >= OST_PERIODS) begin
                  s_nxt.cnt = 32'h0000_0000;
                  s_nxt.state = ST_LOCK;
               end
            end
         end
         ST_LOCK: begin
            s_nxt.cnt = cnt_inc;
            if (!need_pll || cnt_inc >= 32'(PLL_LOCK_CYCLES)) begin
               s_nxt.cnt = 32'h0000_0000;
               s_nxt.state = ST_RUN;
               s_nxt.fetch_start = 1'b1;
            end
         end
         ST_RUN: begin
            if (warm_evt) begin
               s_nxt.state = ST_WARM;
            end
         end
         ST_WARM: begin
            // clock source is left alone on a warm reset
            if (!(s_r.pin_low | wdt_rst)) begin
               s_nxt.state = ST_RUN;
               s_nxt.fetch_start = 1'b1;
            end
         end
      endcase
      // W registers stay uninitialised while the core is held
      if (s_r.state != ST_RUN) begin
         s_nxt.w_init = 15'h0000;
      end
      // a supply drop wins over everything and restarts the chain; a brown-out alone skips the power-on extension
      if (!por_supply_ok || !bor_supply_ok) begin
         s_nxt.state = ST_HOLD;
         s_nxt.cnt = 32'h0000_0000;
         s_nxt.fetch_start = 1'b0;
         s_nxt.cause = (s_nxt.cause & ~COLD_CLEAR_MASK) | (16'h0001 << BIT_BROWNOUT);
      end
      if (!por_supply_ok) begin
         s_nxt.cold_por = 1'b1;
         s_nxt.cause = (s_nxt.cause & ~POR_CLEAR_MASK) | (16'h0001 << BIT_POWER_ON);
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_r.state <= ST_HOLD;
         s_r.cnt <= 32'h0000_0000;
         s_r.cold_por <= 1'b1;
         s_r.cause <= CAUSE_RESET;
         s_r.powerup_delay_timer_sel <= POWERUP_DELAY_TIMER_SEL_RESET;
         s_r.cold_sel <= COLD_CLK_RESET;
         s_r.xtal <= XTAL_RESET;
         s_r.cur_clk <= COLD_CLK_RESET;
         s_r.pin_s1 <= 1'b1;
         s_r.pin_s2 <= 1'b1;
         s_r.pin_cnt <= 4'h0;
         s_r.pin_low <= 1'b0;
         s_r.shadow <= PPS_RESET;
         s_r.w_init <= 15'h0000;
         s_r.rd_ack <= 1'b0;
         s_r.rdata <= 32'h0000_0000;
         s_r.fetch_start <= 1'b0;
         s_r.wake <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // watchdog path is combinational so its reset does not wait for a clock
   assign core_reset = ~running | wdt_rst;
   assign waitrequest = read & ~s_r.rd_ack;
   assign readdata = s_r.rdata;
   assign current_clock_select = s_r.cur_clk;
   assign osc_enable = (s_r.state == ST_OST) | (s_r.state == ST_LOCK) |
      (s_r.state == ST_RUN) | (s_r.state == ST_WARM);
   assign fetch_start = s_r.fetch_start;
   assign reset_vector = RESET_VECTOR;
   assign wake = s_r.wake;

   // ************************************************************
   // assertions
   // ************************************************************
   property p_por_flag;
      @(posedge ref_clk) disable iff (!nrst)
      !por_supply_ok |=> s_r.cause[BIT_POWER_ON] && s_r.cause[BIT_BROWNOUT] && core_reset;
   endproperty
   a_por_flag: assert property (p_por_flag) else $error("power-on flag not set");

   property p_bor_restart;
      @(posedge ref_clk) disable iff (!nrst)
      (por_supply_ok && !bor_supply_ok) |=> s_r.state == ST_HOLD && s_r.cnt == 32'h0 &&
         s_r.cause[BIT_BROWNOUT] && !s_r.cause[BIT_SOFT_RESET];
   endproperty
   a_bor_restart: assert property (p_bor_restart) else $error("brown-out not restarted");

   property p_powerup_delay_timer_hold;
      @(posedge ref_clk) disable iff (!nrst)
      (s_r.state == ST_POWERUP_DELAY_TIMER && cnt_inc < powerup_delay_timer_target && por_supply_ok && bor_supply_ok)
         |=> s_r.state == ST_POWERUP_DELAY_TIMER && core_reset;
   endproperty
   a_powerup_delay_timer_hold: assert property (p_powerup_delay_timer_hold) else $error("power-up delay cut short");

   property p_ost_hold;
      @(posedge ref_clk) disable iff (!nrst)
      (s_r.state == ST_OST && need_ost && s_r.cnt < 32'd1023 && por_supply_ok &&
         bor_supply_ok) |=> s_r.state == ST_OST;
   endproperty
   a_ost_hold: assert property (p_ost_hold) else $error("start-up timer cut short");

   property p_pin_filter;
      @(posedge ref_clk) disable iff (!nrst)
      $rose(s_r.pin_low) |-> s_r.pin_cnt == PIN_FILTER_CYCLES && !$past(s_r.pin_s2);
   endproperty
   a_pin_filter: assert property (p_pin_filter) else $error("pin pulse not filtered");

   property p_soft_reset;
      @(posedge ref_clk) disable iff (!nrst)
      (running && soft_reset_exec && por_supply_ok && bor_supply_ok)
         |=> s_r.state == ST_WARM && s_r.cause[BIT_SOFT_RESET] && core_reset;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset not taken");

   property p_wdt_async;
      @(posedge ref_clk) disable iff (!nrst)
      (watchdog_timeout && !power_saving) |-> core_reset;
   endproperty
   a_wdt_async: assert property (p_wdt_async) else $error("watchdog reset missing");

   property p_wdt_sleep;
      @(posedge ref_clk) disable iff (!nrst)
      (running && watchdog_timeout && power_saving) |-> !core_reset ##1 wake;
   endproperty
   a_wdt_sleep: assert property (p_wdt_sleep) else $error("watchdog reset in sleep");

   property p_illegal;
      @(posedge ref_clk) disable iff (!nrst)
      (running && opcode_valid && opcode[23:16] == ILLEGAL_OPCODE_HI && por_supply_ok &&
         bor_supply_ok) |=> s_r.cause[BIT_ILLEGAL] && s_r.state == ST_WARM;
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal opcode not reset");

   property p_fetch;
      @(posedge ref_clk) disable iff (!nrst)
      fetch_start |-> running && !$past(running) && reset_vector == 24'h0;
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch start misplaced");

endmodule // reset_source_sequencer
`default_nettype wire

// ### tb/osc_model.sv
// oscillator model: one tick every second clock while enabled
`timescale 1ns/1ns
`default_nettype none
module osc_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // oscillator
   input wire logic osc_enable,
   output logic osc_tick
);
   // a stopped oscillator gives no ticks, so start-up waits really stall
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) osc_tick <= 1'b0;
      else osc_tick <= osc_enable & ~osc_tick;
   end
endmodule // osc_model
`default_nettype wire

// ### tb/tb_reset_source_sequencer.sv
// self-checking bench for the reset sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
   $display("FAIL %0t %h %h", $time, (a), (b)); end end
module tb_reset_source_sequencer;
   import reset_seq_pkg::*;
   logic ref_clk = 0, nrst = 0, read = 0, write = 0, waitrequest, osc_tick, osc_enable, wake;
   logic [3:0] address = 0, byteenable = 4'h3, trap_active_prio = 0, trap_new_prio = 0;
   logic [3:0] w_write_idx = 4'h3, w_ptr_idx = 4'h3;
   logic [31:0] writedata = 0, readdata, pps_write_data = 0, pps_live = 0, d;
   logic [2:0] current_clock_select;
   logic por_supply_ok = 0, bor_supply_ok = 0, ext_reset_pin_n = 1, watchdog_timeout = 0;
   logic power_saving = 0, power_save_op = 0, power_save_sleep = 0, watchdog_clear_op = 0;
   logic soft_reset_exec = 0, trap_active = 0, trap_new = 0, opcode_valid = 0, w_write_en = 0;
   logic w_ptr_use = 0, branch_flow_change = 0, vector_flow_change = 0, protect_enable = 1;
   logic pps_write = 0, core_reset, fetch_start;
   logic [23:0] opcode = 0, flow_target = 24'h001800, protect_base = 24'h001000;
   logic [23:0] protect_limit = 24'h001FFF, reset_vector;
   int fails = 0, tests_run = 0, cyc = 0, n;
   reset_source_sequencer #(.BOR_EXT_CYCLES(20), .PLL_LOCK_CYCLES(30), .MS_CYCLES(10))
   i_reset_source_sequencer (.ref_clk, .nrst, .address, .read, .write, .writedata,
      .byteenable, .readdata, .waitrequest, .por_supply_ok, .bor_supply_ok, .osc_tick,
      .current_clock_select, .osc_enable, .ext_reset_pin_n, .watchdog_timeout, .power_saving,
      .power_save_op, .power_save_sleep, .watchdog_clear_op, .wake, .soft_reset_exec,
      .trap_active, .trap_active_prio, .trap_new, .trap_new_prio, .opcode_valid, .opcode,
      .w_write_en, .w_write_idx, .w_ptr_use, .w_ptr_idx, .branch_flow_change,
      .vector_flow_change, .flow_target, .protect_enable, .protect_base, .protect_limit,
      .pps_write, .pps_write_data, .pps_live, .core_reset, .fetch_start, .reset_vector);
   osc_model i_osc_model (.ref_clk, .nrst, .osc_enable, .osc_tick);
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   // ************************************************************
   // bus tasks and helpers
   // ************************************************************
   // request held until the rising edge that sees waitrequest low; data taken at that edge
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      address <= a; writedata <= v; write <= 1'b1;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask
   task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      address <= a; read <= 1'b1;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      v = readdata;
      read <= 1'b0;
   endtask
   // cycles until core reset drops; fetch must start in that cycle
   task automatic wait_run(output int c);
      c = 0;
      do begin @(negedge ref_clk); c++; end while (core_reset !== 1'b0 && c < 9000);
      `CHK(fetch_start, 1'b1)
      `CHK(reset_vector, RESET_VECTOR)
   endtask
   // ************************************************************
   // one event per call, held h cycles
   // ************************************************************
   task automatic ev(input int k, input int h, input logic [15:0] m, input logic [15:0] e,
                     input logic rs, input logic wk);
      logic sr, sw;
      sr = 0; sw = 0;
      bus_wr(OFS_CAUSE, 32'h0);
      @(posedge ref_clk);
      case (k)
         0: soft_reset_exec <= 1'b1;
         1: begin opcode_valid <= 1'b1; opcode <= 24'h3F0000; end
         2: begin trap_active <= 1'b1; trap_active_prio <= 4'hF; trap_new <= 1'b1;
            trap_new_prio <= 4'hD; end
         3: w_ptr_use <= 1'b1;
         4: branch_flow_change <= 1'b1;
         5: pps_live <= 32'h1;
         6: watchdog_timeout <= 1'b1;
         7: ext_reset_pin_n <= 1'b0;
         8: begin power_saving <= 1'b1; watchdog_timeout <= 1'b1; end
         10: vector_flow_change <= 1'b1;
         default: begin power_save_op <= 1'b1; power_save_sleep <= 1'b1; end
      endcase
      repeat (h) begin @(negedge ref_clk); sr |= core_reset; end
      @(posedge ref_clk);
      {soft_reset_exec, opcode_valid, trap_active, trap_new, w_ptr_use} <= 5'h00;
      {branch_flow_change, vector_flow_change, watchdog_timeout, power_saving} <= 4'h0;
      {power_save_op, power_save_sleep} <= 2'h0;
      pps_live <= 32'h0; ext_reset_pin_n <= 1'b1;
      repeat (30) begin @(negedge ref_clk); sr |= core_reset; sw |= wake; end
      bus_rd(OFS_CAUSE, d);
      `CHK(d[15:0] & m, e)
      `CHK(sr, rs)
      `CHK(sw, wk)
   endtask
   // a written W register may serve as a pointer without a reset
   task automatic w_init_chk;
      @(posedge ref_clk) w_write_en <= 1'b1;
      @(posedge ref_clk) w_write_en <= 1'b0;
      ev(3, 1, 16'hFFFF, 16'h0000, 0, 0);
   endtask
   // clear operations wipe the watchdog flag; an idle op leaves its own mark
   task automatic clear_ops;
      bus_wr(OFS_CAUSE, 32'h0010);
      @(posedge ref_clk) watchdog_clear_op <= 1'b1;
      @(posedge ref_clk) watchdog_clear_op <= 1'b0;
      bus_rd(OFS_CAUSE, d);
      `CHK(d[15:0], 16'h0000)
      bus_wr(OFS_CAUSE, 32'h0010);
      @(posedge ref_clk) power_save_op <= 1'b1;
      @(posedge ref_clk) power_save_op <= 1'b0;
      bus_rd(OFS_CAUSE, d);
      `CHK(d[15:0], 16'h0004)
   endtask
   task automatic test_done;
      if (fails == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin fails++; test_done(); end
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1; por_supply_ok <= 1'b1; bor_supply_ok <= 1'b1;
      wait_run(n);
      `CHK(n >= 2800, 1'b1)
      bus_rd(OFS_CAUSE, d);
      `CHK(d[15:0], 16'h0003)
      bus_rd(4'hC, d);
      `CHK(d, 32'h0)
      bus_wr(OFS_CAUSE, 32'hFFFF);
      bus_rd(OFS_CAUSE, d);
      `CHK(d[15:0], CAUSE_WR_MASK)
      `CHK(core_reset, 1'b0)
      bus_wr(OFS_CONFIG, 32'h0000_0130);
      @(posedge ref_clk) bor_supply_ok <= 1'b0;
      repeat (5) @(posedge ref_clk);
      bor_supply_ok <= 1'b1;
      wait_run(n);
      `CHK(n >= 2098, 1'b1)
      `CHK(current_clock_select, CLK_PRIPLL)
      bus_rd(OFS_CAUSE, d);
      `CHK(d[15:0], 16'h0083)
      ev(0, 1, 16'hFFFF, 16'h0040, 1, 0);
      ev(1, 1, 16'hFFFF, 16'h4000, 1, 0);
      ev(2, 1, 16'hFFFF, 16'h8000, 1, 0);
      ev(3, 1, 16'hFFFF, 16'h4000, 1, 0);
      w_init_chk();
      ev(4, 1, 16'hFFFF, 16'h4000, 1, 0);
      ev(5, 1, 16'hFFFF, 16'h0200, 1, 0);
      ev(6, 1, 16'hFFFF, 16'h0010, 1, 0);
      ev(7, 5, 16'hFFFF, 16'h0000, 0, 0);
      ev(7, 30, 16'hFFFF, 16'h0080, 1, 0);
      ev(8, 1, 16'hFFEF, 16'h0000, 0, 1);
      ev(9, 1, 16'hFFFF, 16'h0008, 0, 0);
      ev(10, 1, 16'hFFFF, 16'h4000, 1, 0);
      clear_ops();
      `CHK(current_clock_select, CLK_PRIPLL)
      test_done();
   end
endmodule // tb_reset_source_sequencer
`default_nettype wire
